/* core/smi_pkg.sv */
// Package with constants for the switch monitor event line logic
package smi_pkg;
  // Width of the event status snapshot
  localparam int STAT_W = 16;
  // SPI command frame width and field positions
  localparam int CMD_W = 8;
  localparam int CMD_RW_BIT = 7;
  localparam logic [6:0] STAT_ADDR = 7'h01;
  // Scheme encodings
  localparam logic SCHEME_STATIC = 1'b0;
  localparam logic SCHEME_DYNAMIC = 1'b1;
  localparam logic SCHEME_RESET = SCHEME_STATIC;
  // Clock and timing figures
  localparam int CLK_MHZ = 50;
  localparam int T_ACTIVE_US = 1000;
  localparam int T_INACTIVE_US = 1000;
  localparam int T_IDLE_US = 20;
  localparam int ACTIVE_CYC = T_ACTIVE_US * CLK_MHZ;
  localparam int INACTIVE_CYC = T_INACTIVE_US * CLK_MHZ;
  localparam int IDLE_CYC = T_IDLE_US * CLK_MHZ;
  localparam int CNT_W = 20;
endpackage : smi_pkg

/* core/smi_sync.sv */
// Two flip-flop synchroniser for asynchronous inputs
`timescale 1ns/1ns
module smi_sync #(
  parameter int W = 1
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  // First stage, read only by the second stage
  logic [W-1:0] meta_reg;
  // Two stages on every rising edge
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      meta_reg <= '0;
      sync_o <= '0;
    end else begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end
endmodule : smi_sync

/* core/smi_event_line.sv */
// Event line driver with SPI status snapshot and clear-on-read
`timescale 1ns/1ns
module smi_event_line
  import smi_pkg::*;
#(
  parameter int ACTIVE_CYCLES = ACTIVE_CYC,
  parameter int INACTIVE_CYCLES = INACTIVE_CYC,
  parameter int IDLE_CYCLES = IDLE_CYC
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [STAT_W-1:0] event_set_i,
  input wire logic scheme_i,
  input wire logic scheme_we_i,
  input wire logic trigger_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_sclk_i,
  input wire logic spi_mosi_i,
  output logic [STAT_W-1:0] stat_snap_o,
  output logic [STAT_W-1:0] stat_o,
  output logic scheme_o,
  output logic event_n_o,
  output logic event_n_oe_o
);
  // Line states: released, pulled low, released between pulls in the
  // dynamic scheme, and the idle gap after a status read
  typedef enum logic [1:0] {
    LN_IDLE = 2'b00,
    LN_LOW = 2'b01,
    LN_HIGH = 2'b10,
    LN_HOLD = 2'b11
  } smi_line_t;

  // Synchronised SPI pins; chip select is carried inverted so that the
  // cleared synchroniser reads as deselected and no false frame start
  // follows reset
  logic [2:0] spi_sync;
  // Synced select (active low), clock and data
  logic cs_n_s, sclk_s, mosi_s;
  // Every pin passes two flops before any logic reads it
  smi_sync #(.W(3)) u_sync (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .async_i({~spi_cs_n_i, spi_sclk_i, spi_mosi_i}),
    .sync_o(spi_sync)
  );
  // Undo the inversion of the select bit
  assign cs_n_s = ~spi_sync[2];
  // Link clock, sampled and edge-found on the core clock
  assign sclk_s = spi_sync[1];
  // Command data, aligned with the clock through the same stages
  assign mosi_s = spi_sync[0];

  // Previous synced levels for edge finding
  logic cs_n_reg, sclk_reg;
  // Set at frame start, cleared by the first clock rise
  logic first_reg, first_next;
  // Command bits, shifted in MSB first
  logic [CMD_W-1:0] cmd_reg, cmd_next;
  // Clock rises seen in this frame, saturating
  logic [3:0] bits_reg, bits_next;
  // Frame carried a read of the status register
  logic rd_stat_reg, rd_stat_next;
  // Sticky event status
  logic [STAT_W-1:0] stat_reg, stat_next;
  // Status copy taken at the first clock rise of each frame
  logic [STAT_W-1:0] snap_reg, snap_next;
  // Selected line scheme
  logic scheme_reg, scheme_next;
  // Line state
  smi_line_t line_reg, line_next;
  // Interval counter; one width serves all three intervals
  logic [CNT_W-1:0] cnt_reg, cnt_next;

  // Edge strobes, one core cycle wide each
  wire cs_fall = cs_n_reg & ~cs_n_s;
  wire cs_rise = ~cs_n_reg & cs_n_s;
  // Clock rises only count while the frame is open
  wire sclk_rise = ~sclk_reg & sclk_s & ~cs_n_s;
  // Command word as it will stand after this rise
  wire [CMD_W-1:0] cmd_shift = {cmd_reg[CMD_W-2:0], mosi_s};
  wire cmd_is_rd = ~cmd_shift[CMD_RW_BIT] && (cmd_shift[6:0] == STAT_ADDR);
  // Eighth rise completes the command; later bits are ignored
  wire cmd_done = sclk_rise && (bits_reg == 4'(CMD_W - 1));
  // Clear is applied at the select rise, not when the command ends
  wire clr_stb = cs_rise & rd_stat_reg;
  // Any event this cycle
  wire any_evt = |event_set_i;
  wire dyn_mode = (scheme_reg == SCHEME_DYNAMIC);

  // Cycle count helper, clamped to at least one cycle; counters load
  // n-1 and run to zero, so an interval lasts n cycles
  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = (n < 1) ? CNT_W'(0) : CNT_W'(n - 1);
  endfunction : cyc

  // Frame decode and snapshot; every link strobe here comes from synced pins,
  // so the link may run at any rate that leaves three core cycles per
  // clock phase
  always_comb begin
    first_next = cs_fall ? 1'b1 : (sclk_rise ? 1'b0 : first_reg);
    bits_next = cs_fall ? 4'h0 : ((sclk_rise && bits_reg != 4'hF) ? bits_reg + 4'h1 : bits_reg);
    cmd_next = cs_fall ? '0 : (sclk_rise ? cmd_shift : cmd_reg);
    rd_stat_next = cs_fall ? 1'b0 : (cmd_done ? cmd_is_rd : rd_stat_reg);
    snap_next = snap_reg;
    if (sclk_rise && first_reg) begin
      snap_next = stat_reg;
    end
    // clear on read; new events win
    // Set wins over clear, so an event in the clear cycle is kept
    stat_next = (clr_stb ? '0 : stat_reg) | event_set_i;
    // scheme change gated by trigger
    // A refused write leaves no trace; the host must clear the trigger
    scheme_next = (scheme_we_i && !trigger_i) ? scheme_i : scheme_reg;
  end

  // Line state machine; LOW is the only state that pulls the pin, and
  // HOLD keeps it released for the idle gap that follows a status read
  always_comb begin
    line_next = line_reg;
    // Counter runs down to zero and rests there
    cnt_next = (cnt_reg != '0) ? cnt_reg - CNT_W'(1) : cnt_reg;
    case (line_reg)
      LN_IDLE: begin
        // assert on pending event
        // Status left pending from the idle gap counts as well
        if (any_evt || (stat_reg != '0 && !clr_stb)) begin
          line_next = LN_LOW;
          cnt_next = cyc(ACTIVE_CYCLES);
        end
      end
      LN_LOW: begin
        if (clr_stb) begin
          line_next = LN_HOLD;
          cnt_next = cyc(IDLE_CYCLES);
        end else if (dyn_mode && cnt_reg == '0) begin
          line_next = LN_HIGH;
          cnt_next = cyc(INACTIVE_CYCLES);
        end
      end
      LN_HIGH: begin
        if (clr_stb) begin
          line_next = LN_HOLD;
          cnt_next = cyc(IDLE_CYCLES);
        end else if (cnt_reg == '0) begin
          line_next = LN_LOW;
          cnt_next = cyc(ACTIVE_CYCLES);
        end
      end
      LN_HOLD: begin
        // idle before reassert
        // Events still set the status here; only the line waits
        if (cnt_reg == '0) begin
          line_next = LN_IDLE;
        end
      end
      default: line_next = LN_IDLE;
    endcase
  end

  // State registers; reset is synchronous, so every flop is loaded
  // with a constant on the clock edge that samples it
  always_ff @(posedge core_clk_i) begin
    // Reset: line released, status empty, frame closed
    if (reset_i) begin
      cs_n_reg <= 1'b1;
      sclk_reg <= 1'b0;
      first_reg <= 1'b0;
      bits_reg <= 4'h0;
      cmd_reg <= '0;
      rd_stat_reg <= 1'b0;
      snap_reg <= '0;
      stat_reg <= '0;
      scheme_reg <= SCHEME_RESET;
      line_reg <= LN_IDLE;
      cnt_reg <= '0;
    end else begin
      // Normal running: all next values taken together
      cs_n_reg <= cs_n_s;
      sclk_reg <= sclk_s;
      first_reg <= first_next;
      bits_reg <= bits_next;
      cmd_reg <= cmd_next;
      rd_stat_reg <= rd_stat_next;
      snap_reg <= snap_next;
      stat_reg <= stat_next;
      scheme_reg <= scheme_next;
      line_reg <= line_next;
      cnt_reg <= cnt_next;
    end
  end

  // open-drain pin drive
  // The pin data is always low; only the enable moves, so the line is
  // never driven high and the pull-up alone brings it back
  assign event_n_o = 1'b0;
  assign event_n_oe_o = (line_reg == LN_LOW);
  // Data outputs straight from their registers
  assign stat_snap_o = snap_reg;
  assign stat_o = stat_reg;
  assign scheme_o = scheme_reg;
endmodule : smi_event_line

/* test/smi_host_model.sv */
// SPI host model
`timescale 1ns/1ns
module smi_host_model (
  output logic cs_n_o = 1'h1,
  output logic sclk_o = 1'h0,
  output logic mosi_o = 1'h0
);
  task frame(input logic [7:0] c);
    cs_n_o = 1'h0;
    for (int i = 7; i >= 0; i--) begin
      mosi_o = c[i];
      #80 sclk_o = 1'h1;
      #80 sclk_o = 1'h0;
    end
    #80 cs_n_o = 1'h1;
    // Deselected: flip so no stale bit looks valid
    mosi_o = ~mosi_o;
  endtask : frame
endmodule : smi_host_model

/* test/smi_event_line_monitor.sv */
// Port checks for the event line
`timescale 1ns/1ns
module smi_event_line_monitor
  import smi_pkg::*;
#(
  parameter int ACTIVE_CYCLES = 8
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic scheme_i,
  input wire logic scheme_we_i,
  input wire logic trigger_i,
  input wire logic spi_cs_n_i,
  input wire logic scheme_o,
  input wire logic event_n_oe_o,
  input wire logic [STAT_W-1:0] event_set_i,
  input wire logic [STAT_W-1:0] stat_o
);
  // Latest cycle by which a pulled line is let go in the dynamic scheme
  localparam int TOG_MAX = ACTIVE_CYCLES + 1;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  sequence clr_s; (|stat_o) ##1 (stat_o == '0); endsequence
  sequence up_s; $rose(event_n_oe_o); endsequence
  rst_st_a: assert property (disable iff (1'h0) reset_i |=> !scheme_o && !event_n_oe_o)
    else $error("reset state");
  stat_set_a: assert property (|event_set_i |=> (stat_o & $past(event_set_i)) == $past(event_set_i))
    else $error("event lost");
  trig_blk_a: assert property (trigger_i && scheme_we_i |=> $stable(scheme_o))
    else $error("scheme moved");
  scheme_wr_a: assert property (scheme_we_i && !trigger_i |=> scheme_o == $past(scheme_i))
    else $error("scheme write");
  clr_cs_a: assert property (clr_s |-> spi_cs_n_i) else $error("early clear");
  st_rel_a: assert property (!scheme_o && $fell(event_n_oe_o) |-> spi_cs_n_i)
    else $error("early release");
  dyn_tog_a: assert property ((up_s and scheme_o) |-> ##[1:TOG_MAX] !event_n_oe_o)
    else $error("no toggle");
  no_cause_a: assert property (up_s |-> |stat_o) else $error("line without status");
endmodule : smi_event_line_monitor
bind smi_event_line smi_event_line_monitor #(.ACTIVE_CYCLES(ACTIVE_CYCLES)) mon (
  .core_clk_i(core_clk_i),
  .reset_i(reset_i),
  .scheme_i(scheme_i),
  .scheme_we_i(scheme_we_i),
  .trigger_i(trigger_i),
  .spi_cs_n_i(spi_cs_n_i),
  .scheme_o(scheme_o),
  .event_n_oe_o(event_n_oe_o),
  .event_set_i(event_set_i),
  .stat_o(stat_o)
);

/* test/smi_event_line_tb.sv */
// Event line bench
`timescale 1ns/1ns
module smi_event_line_tb;
  import smi_pkg::*;
  logic core_clk_i = 1'h0, reset_i = 1'h1, scheme_i = 1'h1, scheme_we_i = 1'h0, trigger_i = 1'h0;
  logic spi_cs_n_i, spi_sclk_i, spi_mosi_i, scheme_o, event_n_o, event_n_oe_o;
  logic [STAT_W-1:0] event_set_i = '0, stat_snap_o, stat_o, m;
  logic [7:0] c;
  int err_total = 0, tests_run = 0;
  always #10 core_clk_i = ~core_clk_i;
  // Short counts keep the toggle periods visible
  smi_event_line #(.ACTIVE_CYCLES(8), .INACTIVE_CYCLES(8), .IDLE_CYCLES(4)) DUT (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .event_set_i(event_set_i),
    .scheme_i(scheme_i),
    .scheme_we_i(scheme_we_i),
    .trigger_i(trigger_i),
    .spi_cs_n_i(spi_cs_n_i),
    .spi_sclk_i(spi_sclk_i),
    .spi_mosi_i(spi_mosi_i),
    .stat_snap_o(stat_snap_o),
    .stat_o(stat_o),
    .scheme_o(scheme_o),
    .event_n_o(event_n_o),
    .event_n_oe_o(event_n_oe_o)
  );
  smi_host_model host (.cs_n_o(spi_cs_n_i), .sclk_o(spi_sclk_i), .mosi_o(spi_mosi_i));
  task chk(input string s, input logic [15:0] e, g);
    tests_run++;
    err_total += int'(g !== e);
    if (g !== e) $display("ERROR %s expected %h seen %h", s, e, g);
  endtask : chk
  task wt(input int k); repeat (k) @(negedge core_clk_i); endtask : wt
  task ev;
    m = 16'($urandom) | 16'h1;
    event_set_i = m;
    wt(1);
    event_set_i = '0;
    wt(3);
  endtask : ev
  // Two full periods of 16 cycles
  task automatic hi(input int e);
    int n = 0;
    repeat (32) @(negedge core_clk_i) n += int'(event_n_oe_o);
    chk("high", 16'(e), 16'(n));
  endtask : hi
  task sch(input logic t, e);
    trigger_i = t;
    scheme_we_i = 1'h1;
    wt(1);
    // Strobe stays low a full cycle before any next write
    scheme_we_i = 1'h0;
    wt(1);
    chk("scheme", 16'(e), 16'(scheme_o));
  endtask : sch
  function automatic logic [15:0] after(input logic [7:0] k);
    return k == {1'h0, STAT_ADDR} ? 16'h0 : m;
  endfunction : after
  task complete_run;
    $display("tests_run %0d err_total %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  initial begin
    repeat (20000) @(posedge core_clk_i);
    err_total++;
    complete_run;
  end
  initial begin
    void'($urandom(32'hB3F0));
    wt(5);
    reset_i = 1'h0;
    chk("scheme", 16'(SCHEME_RESET), 16'(scheme_o));
    ev;
    chk("pin", 16'h0, 16'(event_n_o));
    chk("line", 16'h1, 16'(event_n_oe_o));
    for (int i = 0; i < 3; i++) begin
      c = i == 2 ? {1'h0, STAT_ADDR} : {i[0], 7'($urandom_range(2, 127))};
      host.frame(c);
      wt(8);
      chk("stat", after(c), stat_o);
      chk("line", 16'(i != 2), 16'(event_n_oe_o));
    end
    chk("snap", m, stat_snap_o);
    $display("static test done");
    sch(1'h1, 1'h0);
    sch(1'h0, 1'h1);
    for (int j = 0; j < 4; j++) begin
      ev;
      hi(16);
      wt($urandom_range(15));
      host.frame({1'h0, STAT_ADDR});
      wt(8);
      chk("stat", 16'h0, stat_o);
      hi(0);
    end
    $display("dynamic test done");
    complete_run;
  end
endmodule : smi_event_line_tb
